// file: core/embc_pkg.sv
// Purpose: shared constants and types of the embedded memory block
// Assumes: one 10 MHz ref_clk domain, APB register access
// Notes: all offsets are byte addresses, one 32-bit word per register
package embc_pkg;

    // array geometry
    localparam int DW = 16;
    localparam int AW = 4;
    localparam int DEPTH = 16;
    localparam int CNTW = 5;
    localparam int OUT_W = 1 + AW + DW;
    localparam logic [CNTW-1:0] FIFO_FULL_CNT = 5'h10;

    // apb address width and register offsets
    localparam int PAW = 12;
    localparam logic [PAW-1:0] OFF_CTRL = 12'h000;
    localparam logic [PAW-1:0] OFF_REGSEL = 12'h004;
    localparam logic [PAW-1:0] OFF_STATUS = 12'h008;
    localparam logic [PAW-1:0] OFF_INIT_ADDR = 12'h00C;
    localparam logic [PAW-1:0] OFF_INIT_DATA = 12'h010;

    // control register layout and reset value
    localparam int CTRL_W = 12;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WSEL_LSB = 2;
    localparam int CTRL_RSEL_LSB = 5;
    localparam int CTRL_WE_GLB = 8;
    localparam int CTRL_RE_GLB = 9;
    localparam int CTRL_CLR_LOC = 10;
    localparam int CTRL_CLR_GLB = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h0D8;

    // register-stage select bits, set means registered
    localparam int RS_W = 6;
    localparam int RS_WDATA = 0;
    localparam int RS_RDATA = 1;
    localparam int RS_RADDR = 2;
    localparam int RS_WADDR = 3;
    localparam int RS_WE = 4;
    localparam int RS_RE = 5;
    localparam logic [RS_W-1:0] RS_RST = 6'h00;

    // status register layout
    localparam int ST_HIT = 0;
    localparam int ST_FULL = 1;
    localparam int ST_EMPTY = 2;
    localparam int ST_CNT_LSB = 4;

    // synchronised pin vector layout
    localparam int NDED = 4;
    localparam int PIN_W = 8;
    localparam int PIN_GCLK = 0;
    localparam int PIN_DCLK = 1;
    localparam int PIN_GCLR = 5;
    localparam int PIN_GWE = 6;
    localparam int PIN_GRE = 7;

    // memory personalities
    typedef enum logic [1:0] {
        MODE_RAM = 2'b00,
        MODE_ROM = 2'b01,
        MODE_FIFO = 2'b10,
        MODE_CAM = 2'b11
    } embc_mode_t;

    // clock sources for each side
    typedef enum logic [2:0] {
        CS_GLOBAL = 3'b000,
        CS_LOCAL = 3'b001,
        CS_DED0 = 3'b010,
        CS_DED1 = 3'b011,
        CS_DED2 = 3'b100,
        CS_DED3 = 3'b101,
        CS_FREE = 3'b110,
        CS_OFF = 3'b111
    } embc_csel_t;

endpackage : embc_pkg

// file: core/embc_pin_sync.sv
// Purpose: two-flop synchronisers with rising-edge detect for pins
// Assumes: pins are asynchronous to ref_clk
// Notes: edges are taken between the second and third flop only
module embc_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input logic ref_clk,
    input logic srst,
    // raw pins
    input logic [W-1:0] pin_in,
    // synchronised level and one-cycle rise pulse
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise
);

    logic [W-1:0] s1_q; // metastable stage, read by s2_q only
    logic [W-1:0] s2_q; // settled level
    logic [W-1:0] s3_q; // previous settled level

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            // one synchroniser chain per pin
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= pin_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                end
            end
            // rise seen on settled stages only
            always_comb
            begin
                lvl[gi] = s2_q[gi];
                rise[gi] = s2_q[gi] & ~s3_q[gi];
            end
        end
    endgenerate

endmodule : embc_pin_sync

// file: core/embc_cam_match.sv
// Purpose: parallel compare of a key against every stored word
// Assumes: entries and valid bits come straight from the array
// Notes: on several hits the lowest address wins
module embc_cam_match (
    // search key
    input logic [embc_pkg::DW-1:0] key,
    // stored contents
    input logic [embc_pkg::DW-1:0] words [embc_pkg::DEPTH],
    input logic [embc_pkg::DEPTH-1:0] valid,
    // combinational result
    output logic hit,
    output logic [embc_pkg::AW-1:0] addr
);
    import embc_pkg::*;

    logic [DEPTH-1:0] eq; // one comparator per entry

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_cmp
            // all entries compared in the same cycle [R6]
            assign eq[gi] = valid[gi] & (words[gi] == key);
        end
    endgenerate

    // priority encode, descending loop leaves the lowest match
    always_comb
    begin
        hit = |eq; // [R7]
        addr = '0;
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            if (eq[i])
            begin
                addr = AW'(i); // [R6]
            end
        end
    end

endmodule : embc_cam_match

// file: core/embc_top.sv
// Purpose: configurable embedded memory block with apb set-up port
// Assumes: user logic runs on ref_clk, pins are asynchronous
// Notes: side clocks are one-cycle ticks, clears act on ref_clk
//
// Operation
// R1: modes are ram, rom, fifo and cam
// R2: input registers time writes, output stage optional
// R3: read and write proceed together, own clocks
// R4: every register clearable by local, global, reset; local and global clears reach only the input, fifo and output registers
// R5: search takes a word, returns its address
// R6: all locations compared at once
// R7: match found drives hit flag high
// R8: input and output sides clocked separately
// R9: each data, address, strobe path registered optionally
// R10: user logic supplies strobes, clocks, enables, clears
// R11: clock from global, local or four dedicated
// R12: no match keeps hit low, address invalid
module embc_top (
    // clock and reset
    input logic ref_clk,
    input logic srst,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [embc_pkg::PAW-1:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins: global clock, dedicated clocks, global controls
    input logic glb_clk,
    input logic [embc_pkg::NDED-1:0] ded_clk,
    input logic glb_clr,
    input logic glb_we,
    input logic glb_re,
    // local routing from logic cells on ref_clk
    input logic loc_clk,
    input logic clk_ena,
    input logic loc_clr,
    input logic wr_en,
    input logic read_strobe,
    input logic [embc_pkg::AW-1:0] wr_addr,
    input logic [embc_pkg::AW-1:0] rd_addr,
    input logic [embc_pkg::DW-1:0] wr_data,
    // results
    output logic [embc_pkg::DW-1:0] rd_data,
    output logic hit_flag,
    output logic [embc_pkg::AW-1:0] hit_addr,
    output logic fifo_full,
    output logic fifo_empty
);
    import embc_pkg::*;

    // picks one side's tick from the selected clock source
    function automatic logic pick_tick(
        input embc_csel_t sel,
        input logic [PIN_W-1:0] rise,
        input logic lrise
    );
        logic t;
        t = 1'b0;
        unique case (sel)
            CS_GLOBAL: t = rise[PIN_GCLK]; // [R11]
            CS_LOCAL: t = lrise; // [R11]
            CS_DED0: t = rise[PIN_DCLK]; // [R11]
            CS_DED1: t = rise[PIN_DCLK + 1];
            CS_DED2: t = rise[PIN_DCLK + 2];
            CS_DED3: t = rise[PIN_DCLK + 3];
            CS_FREE: t = 1'b1; // every ref_clk cycle
            CS_OFF: t = 1'b0; // side parked
        endcase
        return t;
    endfunction : pick_tick

    // synchronised pins
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;

    // configuration registers
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [RS_W-1:0] regsel_q, regsel_d;
    logic [AW-1:0] init_addr_q, init_addr_d;

    // apb answer registers
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;

    // local clock edge detect, same domain so no synchroniser
    logic loc_clk_q, loc_clk_d;

    // optional input stage
    logic [DW-1:0] wd_q, wd_d;
    logic [AW-1:0] wa_q, wa_d;
    logic we_q, we_d;
    logic [AW-1:0] ra_q, ra_d;
    logic re_q, re_d;

    // fifo bookkeeping
    logic [AW-1:0] wptr_q, wptr_d;
    logic [AW-1:0] rptr_q, rptr_d;
    logic [CNTW-1:0] cnt_q, cnt_d;
    logic full_q, full_d;
    logic empty_q, empty_d;

    // output path: {hit, hit address, data}
    logic [OUT_W-1:0] pipe_q, pipe_d;
    logic [OUT_W-1:0] out_q, out_d;

    // storage; no reset on the array, valid bits do reset
    logic [DW-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] vld_q, vld_d;

    // decoded controls
    embc_mode_t mode;
    logic wr_tick, rd_tick, clr;
    logic we_src, re_src;
    logic [DW-1:0] wd_eff;
    logic [AW-1:0] wa_eff, ra_eff;
    logic we_eff, re_eff;
    logic user_wr, rd_ok, push, pop;
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [DW-1:0] mem_wd;
    logic cam_hit;
    logic [AW-1:0] cam_addr;
    logic [OUT_W-1:0] result;
    logic apb_setup, apb_wr, addr_ok, apb_init;
    logic [31:0] status;

    assign pin_raw = {glb_re, glb_we, glb_clr, ded_clk, glb_clk};

    // pins pass two flops before any logic looks at them
    embc_pin_sync #(
        .W(PIN_W)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in(pin_raw),
        .lvl(pin_lvl),
        .rise(pin_rise)
    );

    // search against the live array contents
    embc_cam_match u_cam (
        .key(wd_eff),
        .words(mem_q),
        .valid(vld_q),
        .hit(cam_hit),
        .addr(cam_addr)
    );

    // side ticks, clear and strobe sources
    always_comb
    begin
        loc_clk_d = loc_clk;
        mode = embc_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
        // each side has its own source, so rates may differ [R3] [R8]
        wr_tick = pick_tick(embc_csel_t'(ctrl_q[CTRL_WSEL_LSB +: 3]),
            pin_rise, loc_clk & ~loc_clk_q) & clk_ena; // [R8]
        rd_tick = pick_tick(embc_csel_t'(ctrl_q[CTRL_RSEL_LSB +: 3]),
            pin_rise, loc_clk & ~loc_clk_q) & clk_ena; // [R3]
        // local or global clear, each enabled in ctrl [R4]
        clr = (ctrl_q[CTRL_CLR_LOC] & loc_clr)
            | (ctrl_q[CTRL_CLR_GLB] & pin_lvl[PIN_GCLR]);
        // strobes from global pins or from logic cells [R10]
        we_src = ctrl_q[CTRL_WE_GLB] ? pin_lvl[PIN_GWE] : wr_en;
        re_src = ctrl_q[CTRL_RE_GLB] ? pin_lvl[PIN_GRE] : read_strobe;
        // per-path choice of registered or direct signal [R9]
        wd_eff = regsel_q[RS_WDATA] ? wd_q : wr_data;
        wa_eff = regsel_q[RS_WADDR] ? wa_q : wr_addr;
        we_eff = regsel_q[RS_WE] ? we_q : we_src;
        ra_eff = regsel_q[RS_RADDR] ? ra_q : rd_addr;
        re_eff = regsel_q[RS_RE] ? re_q : re_src;
    end

    // input stage captures on its own side's tick [R2]
    always_comb
    begin
        wd_d = wd_q;
        wa_d = wa_q;
        we_d = we_q;
        ra_d = ra_q;
        re_d = re_q;
        if (clr)
        begin
            // clear empties the stage [R4]
            wd_d = '0;
            wa_d = '0;
            we_d = 1'b0;
            ra_d = '0;
            re_d = 1'b0;
        end
        else
        begin
            if (wr_tick)
            begin
                wd_d = wr_data; // [R9]
                wa_d = wr_addr;
                we_d = we_src;
            end
            if (rd_tick)
            begin
                ra_d = rd_addr; // [R9]
                re_d = re_src;
            end
        end
    end

    // write and read qualification per mode
    always_comb
    begin
        // rom refuses user writes, full fifo refuses pushes [R1]
        user_wr = wr_tick & we_eff & ~clr & (mode != MODE_ROM)
            & ~((mode == MODE_FIFO) & full_q);
        // read and write may fire in the same cycle [R3]
        rd_ok = rd_tick & re_eff & ~clr
            & ~((mode == MODE_FIFO) & empty_q);
        push = user_wr & (mode == MODE_FIFO);
        pop = rd_ok & (mode == MODE_FIFO);
        // set-up writes over apb take the port before user writes
        mem_we = apb_init | user_wr; // [R2]
        if (apb_init)
        begin
            mem_wa = init_addr_q;
            mem_wd = pwdata[DW-1:0];
        end
        else
        begin
            mem_wa = (mode == MODE_FIFO) ? wptr_q : wa_eff;
            mem_wd = wd_eff;
        end
        vld_d = vld_q;
        if (mem_we)
        begin
            vld_d[mem_wa] = 1'b1;
        end
    end

    // read result per personality [R1]
    always_comb
    begin
        result = '0;
        unique case (mode)
            MODE_RAM: result[DW-1:0] = mem_q[ra_eff];
            MODE_ROM: result[DW-1:0] = mem_q[ra_eff];
            MODE_FIFO: result[DW-1:0] = mem_q[rptr_q];
            MODE_CAM:
            begin
                // data in, address out [R5]
                result[OUT_W-1] = cam_hit; // [R7]
                // a miss zeroes the address, it is not valid [R12]
                result[DW +: AW] = cam_hit ? cam_addr : '0;
            end
        endcase
    end

    // fifo pointers and fill level
    always_comb
    begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        if (clr)
        begin
            wptr_d = '0; // [R4]
            rptr_d = '0;
            cnt_d = '0;
        end
        else
        begin
            if (push)
            begin
                wptr_d = AW'(wptr_q + 1'b1);
            end
            if (pop)
            begin
                rptr_d = AW'(rptr_q + 1'b1);
            end
            cnt_d = CNTW'(cnt_q + CNTW'(push) - CNTW'(pop)); // [R1]
        end
        full_d = (cnt_d == FIFO_FULL_CNT);
        empty_d = (cnt_d == '0);
    end

    // output stage; with the pipe on, data leaves one tick later
    always_comb
    begin
        pipe_d = pipe_q;
        out_d = out_q;
        if (clr)
        begin
            pipe_d = '0; // [R4]
            out_d = '0;
        end
        else if (rd_tick)
        begin
            if (regsel_q[RS_RDATA])
            begin
                out_d = pipe_q; // [R2]
                if (rd_ok)
                begin
                    pipe_d = result;
                end
            end
            else if (rd_ok)
            begin
                out_d = result; // [R9]
            end
        end
    end

    // apb decode: answer registered in setup, write on access edge
    always_comb
    begin
        apb_setup = psel & ~penable;
        apb_wr = psel & penable & pwrite & pready_q & ~pslverr_q;
        addr_ok = (paddr == OFF_CTRL) | (paddr == OFF_REGSEL)
            | (paddr == OFF_STATUS) | (paddr == OFF_INIT_ADDR)
            | (paddr == OFF_INIT_DATA);
        apb_init = apb_wr & (paddr == OFF_INIT_DATA);
        status = '0;
        status[ST_HIT] = out_q[OUT_W-1];
        status[ST_FULL] = full_q;
        status[ST_EMPTY] = empty_q;
        status[ST_CNT_LSB +: CNTW] = cnt_q;
        pready_d = apb_setup;
        pslverr_d = apb_setup & ~addr_ok;
        prdata_d = prdata_q;
        if (apb_setup)
        begin
            prdata_d = '0;
            if (~pwrite)
            begin
                case (paddr)
                    OFF_CTRL: prdata_d = 32'(ctrl_q);
                    OFF_REGSEL: prdata_d = 32'(regsel_q);
                    OFF_STATUS: prdata_d = status;
                    OFF_INIT_ADDR: prdata_d = 32'(init_addr_q);
                    OFF_INIT_DATA: prdata_d = 32'(mem_q[init_addr_q]);
                    default: prdata_d = '0; // unmapped reads zero
                endcase
            end
        end
        ctrl_d = ctrl_q;
        regsel_d = regsel_q;
        init_addr_d = init_addr_q;
        if (apb_wr & (paddr == OFF_CTRL))
        begin
            ctrl_d = pwdata[CTRL_W-1:0]; // [R1] [R8]
        end
        if (apb_wr & (paddr == OFF_REGSEL))
        begin
            regsel_d = pwdata[RS_W-1:0]; // [R9]
        end
        if (apb_wr & (paddr == OFF_INIT_ADDR))
        begin
            init_addr_d = pwdata[AW-1:0];
        end
        else if (apb_init)
        begin
            // data writes step the pointer for streaming loads
            init_addr_d = AW'(init_addr_q + 1'b1);
        end
    end

    // array write port, no reset on the words themselves
    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
        begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    // all control state; srst is the device-wide clear [R4]
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_q <= CTRL_RST;
            regsel_q <= RS_RST;
            init_addr_q <= '0;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            loc_clk_q <= 1'b0;
            wd_q <= '0;
            wa_q <= '0;
            we_q <= 1'b0;
            ra_q <= '0;
            re_q <= 1'b0;
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            pipe_q <= '0;
            out_q <= '0;
            vld_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            regsel_q <= regsel_d;
            init_addr_q <= init_addr_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            loc_clk_q <= loc_clk_d;
            wd_q <= wd_d;
            wa_q <= wa_d;
            we_q <= we_d;
            ra_q <= ra_d;
            re_q <= re_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
            pipe_q <= pipe_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    // outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rd_data = out_q[DW-1:0];
    assign hit_addr = out_q[DW +: AW];
    assign hit_flag = out_q[OUT_W-1];
    assign fifo_full = full_q;
    assign fifo_empty = empty_q;

endmodule : embc_top

// file: testbench/embc_checker.sv
// Purpose: port-level assertions for the memory block
// Assumes: one ref_clk domain, srst synchronous active high
// Notes: watches apb answers and result outputs only
module embc_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic [embc_pkg::PAW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // results
    input wire logic [embc_pkg::DW-1:0] rd_data,
    input wire logic hit_flag,
    input wire logic [embc_pkg::AW-1:0] hit_addr,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    import embc_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable
        && paddr > OFF_INIT_DATA |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    prdata_hold_a: assert property (pready |=> $stable(prdata))
        else $error("prdata moved after access");
    miss_addr_a: assert property (!hit_flag |-> hit_addr == 4'h0)
        else $error("address shown without match");
    fifo_flags_a: assert property (!(fifo_full && fifo_empty))
        else $error("fifo full and empty together");
    reset_out_a: assert property ($fell(srst) |-> fifo_empty
        && !fifo_full && !hit_flag && rd_data == 16'h0)
        else $error("outputs not cleared by reset");
endmodule : embc_checker

bind embc_top embc_checker embc_checker_i (
    .ref_clk, .srst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .rd_data, .hit_flag, .hit_addr, .fifo_full, .fifo_empty
);

// file: testbench/embc_user_logic.sv
// Purpose: user logic driving the block over local routing
// Assumes: strobes change just after a ref_clk edge
// Notes: released strobes go low, address and data lines show the inverse of their last value
module embc_user_logic (
    // clock
    input wire logic ref_clk,
    // strobes and clear
    output logic wr_en,
    output logic read_strobe,
    output logic loc_clr,
    // addresses and data
    output logic [embc_pkg::AW-1:0] wr_addr,
    output logic [embc_pkg::AW-1:0] rd_addr,
    output logic [embc_pkg::DW-1:0] wr_data
);
    import embc_pkg::*;
    initial
    begin
        {wr_en, read_strobe, loc_clr, wr_addr, rd_addr, wr_data} = '0;
    end

    // one strobe cycle after gap idle cycles; slow callers pass a gap
    task automatic put(input logic w, input logic r, input logic c,
        input logic [AW-1:0] wa, input logic [AW-1:0] ra,
        input logic [DW-1:0] d, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        wr_en <= w;
        read_strobe <= r;
        loc_clr <= c;
        wr_addr <= wa;
        rd_addr <= ra;
        wr_data <= d;
        @(posedge ref_clk);
        {wr_en, read_strobe, loc_clr} <= 3'h0;
        // stale values would hide a late sample in the block
        wr_addr <= ~wa;
        rd_addr <= ~ra;
        wr_data <= ~d;
    endtask : put
endmodule : embc_user_logic

// file: testbench/test_embedded_memory_block_cam.sv
// Purpose: self-checking bench for the memory block
// Assumes: both sides tick every cycle unless noted
// Notes: expectations come from an integer array model
module test_embedded_memory_block_cam import embc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [PAW-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic glb_clk, glb_clr, glb_we, glb_re, loc_clk, clk_ena, loc_clr;
    logic wr_en, read_strobe, hit_flag, fifo_full, fifo_empty, e;
    logic [NDED-1:0] ded_clk;
    logic [AW-1:0] wr_addr, rd_addr, hit_addr;
    logic [DW-1:0] wr_data, rd_data;
    int n_errors, num_checks;
    int mem [DEPTH];
    int fq [$];

    embc_top embc_top_i (
        .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .glb_clk, .ded_clk, .glb_clr, .glb_we, .glb_re,
        .loc_clk, .clk_ena, .loc_clr, .wr_en, .read_strobe, .wr_addr,
        .rd_addr, .wr_data, .rd_data, .hit_flag, .hit_addr, .fifo_full,
        .fifo_empty
    );
    embc_user_logic embc_user_logic_i (
        .ref_clk, .wr_en, .read_strobe, .loc_clr, .wr_addr, .rd_addr, .wr_data
    );

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;
    // unselected pins toggle so stray decoding shows up
    always @(posedge ref_clk)
        {glb_clk, ded_clk, loc_clk, glb_we, glb_re} <= 8'($urandom);

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [PAW-1:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // answer taken at the same edge that completes the access
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic u(input logic w, input logic r, input logic c,
        input logic [AW-1:0] wa, input logic [AW-1:0] ra,
        input logic [DW-1:0] d);
        embc_user_logic_i.put(w, r, c, wa, ra, d, $urandom % 3);
        #1;
    endtask : u

    // lowest address holding a word, or -1
    function automatic int first(input int d);
        for (int j = 0; j < DEPTH; j++)
            if (mem[j] == d)
                return j;
        return -1;
    endfunction : first

    initial
    begin
        int a, d, k;
        void'($urandom(32'h7A30E560));
        // reset asserted from time zero, bus and clear pin idle
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, glb_clr} = '0;
        clk_ena = 1'b1;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", 32'(CTRL_RST), q);
        apb(1'b0, OFF_REGSEL, 32'h0);
        chk("regsel", 32'(RS_RST), q);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h4, q);
        apb(1'b1, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        for (k = 0; k < 16; k++)
        begin
            mem[k] = $urandom % 65536;
            u(1'b1, 1'b0, 1'b0, k[3:0], 4'h0, mem[k][15:0]);
        end
        for (k = 0; k < 12; k++)
        begin
            a = $urandom % 16;
            d = $urandom % 65536;
            u(1'b1, 1'b1, 1'b0, a[3:0], a[3:0] ^ 4'h8, d[15:0]);
            chk("ram read", mem[a ^ 8], rd_data);
            mem[a] = d;
        end
        // out stage plus registered read address and strobe: two ticks late
        apb(1'b1, OFF_REGSEL, 32'h26);
        u(1'b0, 1'b1, 1'b0, 4'h0, 4'h1, 16'h0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("piped read", mem[1], rd_data);
        apb(1'b1, OFF_REGSEL, 32'h0);
        apb(1'b1, OFF_CTRL, 32'(CTRL_RST) | 32'h1);
        d = ~mem[3];
        u(1'b1, 1'b0, 1'b0, 4'h3, 4'h0, d[15:0]);
        u(1'b0, 1'b1, 1'b0, 4'h0, 4'h3, 16'h0);
        chk("rom read", mem[3], rd_data);
        apb(1'b1, OFF_CTRL, 32'(CTRL_RST) | 32'h3);
        apb(1'b1, OFF_INIT_ADDR, 32'h5);
        apb(1'b1, OFF_INIT_DATA, 32'(mem[9]));
        mem[5] = mem[9];
        apb(1'b0, OFF_INIT_ADDR, 32'h0);
        chk("init addr", 32'h6, q);
        for (k = 0; k < 10; k++)
        begin
            a = (k == 0) ? 9 : $urandom % 16;
            u(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, mem[a][15:0]);
            chk("cam hit", 32'h1, hit_flag);
            chk("cam addr", first(mem[a]), hit_addr);
            chk("cam data", 32'h0, rd_data);
        end
        do
            d = $urandom % 65536;
        while (first(d) >= 0);
        // clock enable low: no read tick, the last hit must stand
        @(posedge ref_clk) clk_ena <= 1'b0;
        u(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, d[15:0]);
        chk("gated hit", 32'h1, hit_flag);
        @(posedge ref_clk) clk_ena <= 1'b1;
        u(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, d[15:0]);
        chk("miss hit", 32'h0, hit_flag);
        chk("miss addr", 32'h0, hit_addr);
        apb(1'b1, OFF_CTRL, 32'(CTRL_RST) | 32'hC02);
        u(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 16'h0);
        chk("fifo empty", 32'h1, fifo_empty);
        for (k = 0; k < 17; k++)
        begin
            d = $urandom % 65536;
            if (k < 16)
                fq.push_back(d);
            u(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, d[15:0]);
        end
        chk("fifo full", 32'h1, fifo_full);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status full", 32'h102, q);
        while (fq.size() > 0)
        begin
            u(1'b0, 1'b1, 1'b0, 4'h0, 4'h0, 16'h0);
            chk("fifo data", fq.pop_front(), rd_data);
        end
        chk("fifo empty", 32'h1, fifo_empty);
        u(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 16'h1234);
        chk("fifo pushed", 32'h0, fifo_empty);
        @(posedge ref_clk);
        glb_clr <= 1'b1;
        repeat (6) @(posedge ref_clk);
        glb_clr <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("glb clear", 32'h1, fifo_empty);
        chk("glb clear data", 32'h0, rd_data);
        complete_run();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #2000000;
        n_errors++;
        complete_run();
    end
endmodule : test_embedded_memory_block_cam
